// ==== mof_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module mof_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  assign empty = (wr_ptr == rd_ptr);
  assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== mof_formatter.sv ====
`timescale 1ns/1ps
`default_nettype none
module mof_formatter #(
  parameter longint ALIGN_CYCLES = mof_pkg::ALIGN_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] roll_angle,
  input wire logic [15:0] pitch_angle,
  input wire logic [15:0] heave_mm,
  input wire logic [15:0] roll_cdeg,
  input wire logic [15:0] pitch_cdeg,
  input wire logic [15:0] heading_cdeg,
  input wire logic [15:0] normalised_roll,
  input wire logic [15:0] normalised_pitch,
  input wire logic [15:0] heave_halfcm,
  input wire logic [2:0] aid_mode,
  input wire logic sensor_unstable,
  input wire logic restart,
  input wire logic send_binary,
  input wire logic send_profiler,
  input wire logic prefix_sel,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] status_char,
  output logic [2:0] status_code,
  output logic aligning,
  output logic busy
);

  // ***************************************
  // helpers
  // ***************************************
  function automatic logic [16:0] mag_of(input logic [15:0] v);
    logic [16:0] e;
    e = {v[15], v};
    return e[16] ? (17'h0_0000 - e) : e;
  endfunction

  function automatic logic [7:0] sign_of(input logic [15:0] v);
    return v[15] ? mof_pkg::B_MINUS : mof_pkg::B_PLUS;
  endfunction

  // decimal digit pos (0 = units) of a magnitude, as ascii
  function automatic logic [7:0] digit_of(input logic [16:0] mag, input logic [2:0] pos);
    logic [16:0] q;
    q = mag;
    case (pos)
      3'h1: q = mag / 17'd10;
      3'h2: q = mag / 17'd100;
      3'h3: q = mag / 17'd1000;
      3'h4: q = mag / 17'd10000;
      default: q = mag;
    endcase
    return mof_pkg::B_ZERO + {4'h0, 4'(q % 17'd10)};
  endfunction

  // ***************************************
  // stability and aiding status
  // ***************************************
  logic [mof_pkg::ALIGN_W-1:0] align_cnt;
  logic unstable;
  logic [7:0] next_status_char;
  logic [2:0] next_status_code;

  always_ff @(posedge clk) begin
    if (sys_rst || restart) begin
      align_cnt <= '0;
    end else if (align_cnt < mof_pkg::ALIGN_W'(ALIGN_CYCLES)) begin
      align_cnt <= align_cnt + 1'b1;
    end
  end

  assign unstable = (align_cnt < mof_pkg::ALIGN_W'(ALIGN_CYCLES)) || sensor_unstable;

  always_comb begin
    next_status_char = mof_pkg::CH_UNAIDED;
    next_status_code = mof_pkg::CODE_UNAIDED;
    case (aid_mode)
      mof_pkg::AID_SPEED: begin
        next_status_char = mof_pkg::CH_SPEED;
        next_status_code = mof_pkg::CODE_SPEED;
      end
      mof_pkg::AID_HEAD: begin
        next_status_char = mof_pkg::CH_HEAD;
        next_status_code = mof_pkg::CODE_HEAD;
      end
      mof_pkg::AID_MAG: begin
        next_status_char = mof_pkg::CH_MAG;
        next_status_code = mof_pkg::CODE_UNAIDED;
      end
      mof_pkg::AID_SPEED_MAG: begin
        next_status_char = mof_pkg::CH_SPEED_MAG;
        next_status_code = mof_pkg::CODE_SPEED;
      end
      mof_pkg::AID_FULL: begin
        next_status_char = mof_pkg::CH_FULL;
        next_status_code = mof_pkg::CODE_FULL;
      end
      default: begin
        next_status_char = mof_pkg::CH_UNAIDED;
        next_status_code = mof_pkg::CODE_UNAIDED;
      end
    endcase
    if (unstable) begin
      next_status_char = next_status_char | mof_pkg::CASE_BIT;
      next_status_code = next_status_code | 3'h1;
    end
  end

  // registered status outputs; the message status slot takes next_status_code at launch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_char <= mof_pkg::CH_UNAIDED | mof_pkg::CASE_BIT;
      status_code <= mof_pkg::CODE_UNAIDED | 3'h1;
      aligning <= 1'b1;
    end else begin
      status_char <= next_status_char;
      status_code <= next_status_code;
      aligning <= unstable;
    end
  end

  // ***************************************
  // request capture
  // ***************************************
  // set wins over clear so a request in the launch cycle is not lost
  mof_pkg::mof_state_t state;
  logic pend_bin;
  logic pend_prof;
  logic pend_qry;
  logic launch;
  mof_pkg::mof_msg_t next_msg;
  logic query_hit;

  assign query_hit = rx_valid && (rx_byte == mof_pkg::B_QUERY);
  assign launch = (state == mof_pkg::ST_IDLE) && (pend_bin || pend_prof || pend_qry);

  always_comb begin
    if (pend_bin) begin
      next_msg = mof_pkg::MSG_BIN;
    end else if (pend_qry) begin
      next_msg = mof_pkg::MSG_QUERY;
    end else begin
      next_msg = mof_pkg::MSG_PROF;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend_bin <= 1'b0;
      pend_prof <= 1'b0;
      pend_qry <= 1'b0;
    end else begin
      pend_bin <= send_binary || (pend_bin && !(launch && next_msg == mof_pkg::MSG_BIN));
      pend_qry <= query_hit || (pend_qry && !(launch && next_msg == mof_pkg::MSG_QUERY));
      pend_prof <= send_profiler || (pend_prof && !(launch && next_msg == mof_pkg::MSG_PROF));
    end
  end

  // ***************************************
  // snapshot
  // ***************************************
  // one capture per message keeps fields from mixing two sensor updates
  mof_pkg::mof_msg_t msg;
  logic pref;
  logic [15:0] s_roll;
  logic [15:0] s_pitch;
  logic [15:0] s_heave;
  logic [15:0] s_roll_cd;
  logic [15:0] s_pitch_cd;
  logic [15:0] s_head_cd;
  logic [15:0] s_nroll;
  logic [15:0] s_npitch;
  logic [15:0] s_heave_hc;
  logic [2:0] s_code;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      msg <= mof_pkg::MSG_BIN;
      pref <= 1'b0;
      s_roll <= 16'h0000;
      s_pitch <= 16'h0000;
      s_heave <= 16'h0000;
      s_roll_cd <= 16'h0000;
      s_pitch_cd <= 16'h0000;
      s_head_cd <= 16'h0000;
      s_nroll <= 16'h0000;
      s_npitch <= 16'h0000;
      s_heave_hc <= 16'h0000;
      s_code <= 3'h0;
    end else if (launch) begin
      msg <= next_msg;
      pref <= prefix_sel;
      s_roll <= roll_angle;
      s_pitch <= pitch_angle;
      s_heave <= heave_mm;
      s_roll_cd <= roll_cdeg;
      s_pitch_cd <= pitch_cdeg;
      s_head_cd <= heading_cdeg;
      s_nroll <= normalised_roll;
      s_npitch <= normalised_pitch;
      s_heave_hc <= heave_halfcm;
      s_code <= next_status_code;
    end
  end

  // ***************************************
  // serializer
  // ***************************************
  logic [4:0] idx;
  logic [4:0] last_idx;
  logic [4:0] ppos;
  logic [4:0] qpos;
  logic [1:0] qfld;
  logic [15:0] qval;
  logic [7:0] next_byte;
  logic push;
  logic fifo_in_ready;

  assign push = (state == mof_pkg::ST_SEND) && fifo_in_ready;

  always_comb begin
    case (msg)
      mof_pkg::MSG_PROF: last_idx = pref ? mof_pkg::PROF_LAST_PREF : mof_pkg::PROF_LAST_PLAIN;
      mof_pkg::MSG_QUERY: last_idx = mof_pkg::QRY_LAST;
      default: last_idx = mof_pkg::BIN_LAST;
    endcase
  end

  // plain sentence skips the prefix letter at position 1
  assign ppos = (pref || idx == 5'h00) ? idx : idx + 5'h01;
  assign qfld = 2'(idx / mof_pkg::QRY_FIELD);
  assign qpos = idx % mof_pkg::QRY_FIELD;

  always_comb begin
    case (qfld)
      2'h0: qval = s_nroll;
      2'h1: qval = s_npitch;
      default: qval = s_heave_hc;
    endcase
  end

  always_comb begin
    next_byte = mof_pkg::B_FRAME;
    case (msg)
      mof_pkg::MSG_PROF: begin
        case (ppos)
          5'h00: next_byte = mof_pkg::B_DOLLAR;
          5'h01: next_byte = mof_pkg::B_P;
          5'h02: next_byte = mof_pkg::B_R;
          5'h03: next_byte = mof_pkg::B_D;
          5'h04: next_byte = mof_pkg::B_I;
          5'h05: next_byte = mof_pkg::B_D;
          5'h06, 5'h0E, 5'h16: next_byte = mof_pkg::B_COMMA;
          5'h07: next_byte = sign_of(s_pitch_cd);
          5'h08: next_byte = digit_of(mag_of(s_pitch_cd), 3'h4);
          5'h09: next_byte = digit_of(mag_of(s_pitch_cd), 3'h3);
          5'h0A: next_byte = digit_of(mag_of(s_pitch_cd), 3'h2);
          5'h0B, 5'h13, 5'h1A: next_byte = mof_pkg::B_DOT;
          5'h0C: next_byte = digit_of(mag_of(s_pitch_cd), 3'h1);
          5'h0D: next_byte = digit_of(mag_of(s_pitch_cd), 3'h0);
          5'h0F: next_byte = sign_of(s_roll_cd);
          5'h10: next_byte = digit_of(mag_of(s_roll_cd), 3'h4);
          5'h11: next_byte = digit_of(mag_of(s_roll_cd), 3'h3);
          5'h12: next_byte = digit_of(mag_of(s_roll_cd), 3'h2);
          5'h14: next_byte = digit_of(mag_of(s_roll_cd), 3'h1);
          5'h15: next_byte = digit_of(mag_of(s_roll_cd), 3'h0);
          5'h17: next_byte = digit_of({1'b0, s_head_cd}, 3'h4);
          5'h18: next_byte = digit_of({1'b0, s_head_cd}, 3'h3);
          5'h19: next_byte = digit_of({1'b0, s_head_cd}, 3'h2);
          5'h1B: next_byte = digit_of({1'b0, s_head_cd}, 3'h1);
          5'h1C: next_byte = digit_of({1'b0, s_head_cd}, 3'h0);
          5'h1D: next_byte = mof_pkg::B_CR;
          default: next_byte = mof_pkg::B_LF;
        endcase
      end
      mof_pkg::MSG_QUERY: begin
        if (idx == mof_pkg::QRY_LAST - 5'h01) begin
          next_byte = mof_pkg::B_CR;
        end else if (idx == mof_pkg::QRY_LAST) begin
          next_byte = mof_pkg::B_LF;
        end else if (qpos == 5'h06) begin
          next_byte = mof_pkg::B_COMMA;
        end else if (qpos == 5'h00) begin
          next_byte = sign_of(qval);
        end else begin
          next_byte = digit_of(mag_of(qval), 3'(5'h05 - qpos));
        end
      end
      default: begin
        case (idx)
          5'h01: next_byte = s_roll[15:8];
          5'h02: next_byte = s_roll[7:0];
          5'h03: next_byte = s_pitch[15:8];
          5'h04: next_byte = s_pitch[7:0];
          5'h05: next_byte = s_heave[15:8];
          5'h06: next_byte = s_heave[7:0];
          5'h07: next_byte = {5'h00, s_code};
          default: next_byte = mof_pkg::B_FRAME;
        endcase
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= mof_pkg::ST_IDLE;
    end else begin
      case (state)
        mof_pkg::ST_IDLE: if (launch) begin
          state <= mof_pkg::ST_SEND;
        end
        mof_pkg::ST_SEND: if (push && idx == last_idx) begin
          state <= mof_pkg::ST_IDLE;
        end
        default: state <= mof_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || launch) begin
      idx <= 5'h00;
    end else if (push) begin
      idx <= idx + 5'h01;
    end
  end

  // ***************************************
  // output buffer and register stage
  // ***************************************
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_take;

  assign fifo_take = fifo_valid && (!tx_valid || tx_ready);

  mof_fifo #(
    .W(mof_pkg::FIFO_W),
    .D(mof_pkg::FIFO_D)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_data(next_byte),
    .in_valid(state == mof_pkg::ST_SEND),
    .in_ready(fifo_in_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_take)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
    end else if (fifo_take) begin
      tx_valid <= 1'b1;
      tx_data <= fifo_data;
    end else if (tx_ready) begin
      tx_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= launch || (state == mof_pkg::ST_SEND && !(push && idx == last_idx));
    end
  end
endmodule
`default_nettype wire

// ==== mof_formatter_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// output checker
// ****************
module mof_formatter_chk #(
  parameter longint ALIGN_CYCLES = 64'h32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic sensor_unstable,
  input wire logic send_binary,
  input wire logic send_profiler,
  input wire logic [7:0] rx_byte,
  input wire logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] status_char,
  input wire logic [2:0] status_code,
  input wire logic aligning,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic req;
  assign req = send_binary | send_profiler | (rx_valid & (rx_byte == 8'h4F));

  chk_reset_state: assert property (@(posedge clk) disable iff (1'b0)
    sys_rst |=> !tx_valid && !busy && aligning && status_code == 3'h1)
    else $error("outputs wrong after reset");
  chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped or changed while sink stalled");
  chk_case_code: assert property (status_char[5] == status_code[0])
    else $error("letter case and code parity disagree");
  chk_letter_set: assert property (status_char inside {8'h4E, 8'h6E, 8'h53, 8'h73,
    8'h43, 8'h63, 8'h4D, 8'h6D, 8'h42, 8'h62, 8'h41, 8'h61})
    else $error("status letter outside the set");
  chk_align_case: assert property (aligning == status_char[5])
    else $error("unstable flag and letter case disagree");
  chk_restart_align: assert property (restart |-> ##[1:3] aligning)
    else $error("restart did not flag data unstable");
  chk_unstable_flag: assert property (sensor_unstable |-> ##[1:3] aligning)
    else $error("sensor instability not reported");
  chk_first_byte: assert property ($rose(busy) && !tx_valid |-> ##2 tx_valid &&
    (tx_data inside {8'h10, 8'h24, 8'h2B, 8'h2D}))
    else $error("message does not open with its lead byte");
  chk_req_launch: assert property (req && !busy |-> ##[1:3] busy)
    else $error("request not launched");

  cover property (send_binary && !busy);
  cover property (rx_valid && rx_byte == 8'h4F);
  cover property (tx_valid && !tx_ready);
  cover property ($fell(aligning));
endmodule

bind mof_formatter mof_formatter_chk #(.ALIGN_CYCLES(ALIGN_CYCLES)) i_mof_formatter_chk (
  .clk(clk), .sys_rst(sys_rst), .restart(restart), .sensor_unstable(sensor_unstable),
  .send_binary(send_binary), .send_profiler(send_profiler), .rx_byte(rx_byte),
  .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .status_char(status_char), .status_code(status_code), .aligning(aligning), .busy(busy));
`default_nettype wire

// ==== mof_pkg.sv ====
// What this block does
// - The status letter is reported on status_char; the status byte slot of the binary attitude message carries the numeric status code.
// - Unaided operation is reported as N when stable and n when unstable.
// - Speed-aided operation is reported as S or s, and heading-aided operation as C or c, upper case when stable.
// - Internal magnetic compass heading is reported as M when stable and m while still unstable.
// - External speed with internal magnetic heading is reported as B when stable and b when unstable.
// - Full aiding with external speed and heading is reported as A when stable and a when unstable.
// - After power-on or restart the data are flagged unstable for the alignment period of about five minutes.
// - The profiler sentence comes in a plain and a P-prefixed form, carries pitch, roll and heading by commas and ends in 13, 10.
// - Profiler pitch and roll are a sign then ddd.dd with leading zeroes, pitch bow up and roll port up positive.
// - Profiler heading is unsigned true degrees ddd.dd with leading zeroes.
// - On the single letter O the block replies with roll and pitch in 0.0005 steps of -1..1, then heave in 0.5 cm steps.
// - The fourth reply element repeats the current heave; roll port up, pitch stern up, heave up positive.
// - The binary packet is 0x10, roll hi/lo, pitch hi/lo, heave hi/lo, status, 0x10.
// - Each binary field is 16-bit two's complement, most significant byte first.
// - Binary roll and pitch use 65536 counts per circle, heave one millimetre per count.
// - The binary status byte is 0-7: unaided, speed, heading, full pairs, even stable and odd unstable.
package mof_pkg;

  // ***************************************
  // timing
  // ***************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int ALIGN_TIME_S = 300;
  localparam longint ALIGN_CYCLES = longint'(ALIGN_TIME_S) * longint'(CLK_HZ);
  localparam int ALIGN_W = 36;

  // ***************************************
  // fifo
  // ***************************************
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 8;

  // ***************************************
  // aiding modes and states
  // ***************************************
  typedef enum logic [2:0] {
    AID_NONE      = 3'h0,
    AID_SPEED     = 3'h1,
    AID_HEAD      = 3'h2,
    AID_MAG       = 3'h3,
    AID_SPEED_MAG = 3'h4,
    AID_FULL      = 3'h5
  } mof_aid_t;

  typedef enum logic [1:0] {
    MSG_BIN   = 2'h0,
    MSG_PROF  = 2'h1,
    MSG_QUERY = 2'h2
  } mof_msg_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_SEND = 2'h2
  } mof_state_t;

  // ***************************************
  // status letters, upper case; lower case adds CASE_BIT
  // ***************************************
  localparam logic [7:0] CH_UNAIDED = 8'h4E;
  localparam logic [7:0] CH_SPEED = 8'h53;
  localparam logic [7:0] CH_HEAD = 8'h43;
  localparam logic [7:0] CH_MAG = 8'h4D;
  localparam logic [7:0] CH_SPEED_MAG = 8'h42;
  localparam logic [7:0] CH_FULL = 8'h41;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // binary status codes, stable values; unstable adds one
  localparam logic [2:0] CODE_UNAIDED = 3'h0;
  localparam logic [2:0] CODE_SPEED = 3'h2;
  localparam logic [2:0] CODE_HEAD = 3'h4;
  localparam logic [2:0] CODE_FULL = 3'h6;

  // ***************************************
  // message bytes
  // ***************************************
  localparam logic [7:0] B_FRAME = 8'h10;
  localparam logic [7:0] B_DOLLAR = 8'h24;
  localparam logic [7:0] B_P = 8'h50;
  localparam logic [7:0] B_R = 8'h52;
  localparam logic [7:0] B_D = 8'h44;
  localparam logic [7:0] B_I = 8'h49;
  localparam logic [7:0] B_COMMA = 8'h2C;
  localparam logic [7:0] B_DOT = 8'h2E;
  localparam logic [7:0] B_PLUS = 8'h2B;
  localparam logic [7:0] B_MINUS = 8'h2D;
  localparam logic [7:0] B_ZERO = 8'h30;
  localparam logic [7:0] B_CR = 8'h0D;
  localparam logic [7:0] B_LF = 8'h0A;
  localparam logic [7:0] B_QUERY = 8'h4F;

  // last byte index of each message, and query field width
  localparam logic [4:0] BIN_LAST = 5'h08;
  localparam logic [4:0] PROF_LAST_PLAIN = 5'h1D;
  localparam logic [4:0] PROF_LAST_PREF = 5'h1E;
  localparam logic [4:0] QRY_LAST = 5'h1C;
  localparam logic [4:0] QRY_FIELD = 5'h07;

endpackage

// ==== mof_sink_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// instrument on the serial side
// ****************
module mof_sink_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic stall_en,
  input wire logic ask,
  output logic tx_ready,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  logic [7:0] got[$];
  // random stalls back up the fifo so the serializer must wait
  always @(posedge clk) begin
    if (!sys_rst && tx_valid && tx_ready) got.push_back(tx_data);
    tx_ready <= sys_rst ? 1'b0 : (stall_en ? 1'($urandom_range(0, 1)) : 1'b1);
  end
  // between strobes the byte line wanders, so a stale letter never looks valid
  always @(posedge clk) begin
    rx_valid <= ask;
    rx_byte <= ask ? mof_pkg::B_QUERY : (sys_rst ? 8'hA5 : ~rx_byte);
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ****************
  // signals
  // ****************
  localparam longint ALIGN_N = 64'h96;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] roll_angle = 16'h0, pitch_angle = 16'h0, heave_mm = 16'h0;
  logic [15:0] roll_cdeg = 16'h0, pitch_cdeg = 16'h0, heading_cdeg = 16'h0;
  logic [15:0] normalised_roll = 16'h0, normalised_pitch = 16'h0, heave_halfcm = 16'h0;
  logic [2:0] aid_mode = 3'h0;
  logic sensor_unstable = 1'b0, restart = 1'b0, send_binary = 1'b0, send_profiler = 1'b0;
  logic prefix_sel = 1'b0, stall_en = 1'b0, ask = 1'b0;
  logic [7:0] rx_byte, tx_data, status_char;
  logic rx_valid, tx_valid, tx_ready, aligning, busy;
  logic [2:0] status_code;
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int seed;

  initial forever #10 clk = ~clk;
  always @(posedge clk) cyc <= (sys_rst || restart) ? 0 : cyc + 1;

  mof_formatter #(.ALIGN_CYCLES(ALIGN_N)) i_mof_formatter (.clk(clk), .sys_rst(sys_rst),
    .roll_angle(roll_angle), .pitch_angle(pitch_angle), .heave_mm(heave_mm),
    .roll_cdeg(roll_cdeg), .pitch_cdeg(pitch_cdeg), .heading_cdeg(heading_cdeg),
    .normalised_roll(normalised_roll), .normalised_pitch(normalised_pitch),
    .heave_halfcm(heave_halfcm), .aid_mode(aid_mode), .sensor_unstable(sensor_unstable),
    .restart(restart), .send_binary(send_binary), .send_profiler(send_profiler),
    .prefix_sel(prefix_sel), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .status_char(status_char),
    .status_code(status_code), .aligning(aligning), .busy(busy));
  mof_sink_model i_mof_sink_model (.clk(clk), .sys_rst(sys_rst), .tx_data(tx_data),
    .tx_valid(tx_valid), .stall_en(stall_en), .ask(ask), .tx_ready(tx_ready),
    .rx_byte(rx_byte), .rx_valid(rx_valid));

  // ****************
  // helpers
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  function automatic logic [7:0] exp_char(input logic [2:0] m, input logic u);
    logic [7:0] c;
    case (m)
      3'h1: c = mof_pkg::CH_SPEED;
      3'h2: c = mof_pkg::CH_HEAD;
      3'h3: c = mof_pkg::CH_MAG;
      3'h4: c = mof_pkg::CH_SPEED_MAG;
      3'h5: c = mof_pkg::CH_FULL;
      default: c = mof_pkg::CH_UNAIDED;
    endcase
    return u ? (c | mof_pkg::CASE_BIT) : c;
  endfunction

  function automatic logic [2:0] exp_code(input logic [2:0] m, input logic u);
    case (m)
      3'h1, 3'h4: return {2'h1, u};
      3'h2: return {2'h2, u};
      3'h5: return {2'h3, u};
      default: return {2'h0, u};
    endcase
  endfunction

  // five digits, most significant first; zero is sent with a plus sign
  function automatic void add_num(input int v, input bit sgn, input bit dot);
    int a;
    int p;
    a = (v < 0) ? -v : v;
    p = 10000;
    if (sgn) exp_q.push_back((v < 0) ? mof_pkg::B_MINUS : mof_pkg::B_PLUS);
    for (int i = 0; i < 5; i++) begin
      if (dot && i == 3) exp_q.push_back(mof_pkg::B_DOT);
      exp_q.push_back(mof_pkg::B_ZERO + 8'((a / p) % 10));
      p = p / 10;
    end
  endfunction

  task automatic randomize_in;
    roll_angle <= 16'($urandom);
    pitch_angle <= 16'($urandom);
    heave_mm <= 16'($urandom);
    roll_cdeg <= 16'($urandom_range(0, 36000) - 18000);
    pitch_cdeg <= 16'($urandom_range(0, 36000) - 18000);
    heading_cdeg <= 16'($urandom_range(0, 35999));
    normalised_roll <= 16'($urandom_range(0, 4000) - 2000);
    normalised_pitch <= 16'($urandom_range(0, 4000) - 2000);
    heave_halfcm <= 16'($urandom);
    stall_en <= 1'($urandom_range(0, 1));
  endtask

  // expected bytes in launch order: binary, then query, then profiler
  task automatic build(input logic [2:0] kinds, input logic u);
    logic [15:0] f[3];
    if (kinds[0]) begin
      f = '{roll_angle, pitch_angle, heave_mm};
      exp_q.push_back(mof_pkg::B_FRAME);
      foreach (f[i]) begin
        exp_q.push_back(f[i][15:8]);
        exp_q.push_back(f[i][7:0]);
      end
      exp_q.push_back({5'h00, exp_code(aid_mode, u)});
      exp_q.push_back(mof_pkg::B_FRAME);
    end
    if (kinds[2]) begin
      f = '{normalised_roll, normalised_pitch, heave_halfcm};
      for (int i = 0; i < 4; i++) begin
        add_num(int'($signed(f[(i < 3) ? i : 2])), 1'b1, 1'b0);
        exp_q.push_back((i < 3) ? mof_pkg::B_COMMA : mof_pkg::B_CR);
      end
      exp_q.push_back(mof_pkg::B_LF);
    end
    if (kinds[1]) begin
      f = '{pitch_cdeg, roll_cdeg, heading_cdeg};
      exp_q.push_back(mof_pkg::B_DOLLAR);
      if (prefix_sel) exp_q.push_back(mof_pkg::B_P);
      exp_q.push_back(mof_pkg::B_R);
      exp_q.push_back(mof_pkg::B_D);
      exp_q.push_back(mof_pkg::B_I);
      exp_q.push_back(mof_pkg::B_D);
      for (int i = 0; i < 3; i++) begin
        exp_q.push_back(mof_pkg::B_COMMA);
        add_num((i < 2) ? int'($signed(f[i])) : int'(f[i]), i < 2, 1'b1);
      end
      exp_q.push_back(mof_pkg::B_CR);
      exp_q.push_back(mof_pkg::B_LF);
    end
  endtask

  task automatic collect;
    int k;
    for (k = 0; k < 3000 && i_mof_sink_model.got.size() < exp_q.size(); k++) @(posedge clk);
    if (k == 3000) begin
      n_fail++;
      $display("[FAIL] %0t message incomplete", $time);
      finish_test();
    end
    tick(20);
    check(busy, 1'b0);
    check(i_mof_sink_model.got.size(), exp_q.size());
    foreach (exp_q[i]) check(i_mof_sink_model.got[i], exp_q[i]);
    i_mof_sink_model.got.delete();
    exp_q.delete();
  endtask

  task automatic send(input logic [2:0] kinds, input logic u);
    @(posedge clk);
    randomize_in();
    tick(3);
    build(kinds, u);
    send_binary <= kinds[0];
    send_profiler <= kinds[1];
    ask <= kinds[2];
    @(posedge clk);
    send_binary <= 1'b0;
    send_profiler <= 1'b0;
    ask <= 1'b0;
    tick(5);
    // queued messages snapshot at their own launch, so only a lone one may see new inputs
    if ($countones(kinds) == 1) randomize_in();
    collect();
  endtask

  task automatic wait_aligned;
    int k;
    for (k = 0; k < 400 && aligning === 1'b1; k++) @(posedge clk);
    if (k == 400) begin
      n_fail++;
      $display("[FAIL] %0t alignment never ends", $time);
      finish_test();
    end
    check(32'(cyc >= ALIGN_N - 3 && cyc <= ALIGN_N + 6), 32'h1);
  endtask

  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    $display("[FAIL] %0t run did not end", $time);
    finish_test();
  end

  initial begin
    seed = $urandom(49);
    tick(6);
    sys_rst <= 1'b0;
    tick(2);
    check(aligning, 1'b1);
    check(status_char, 8'h6E);
    send(3'h1, 1'b1);
    wait_aligned();
    for (int m = 0; m < 8; m++) begin
      for (int u = 0; u < 2; u++) begin
        aid_mode <= 3'(m);
        sensor_unstable <= 1'(u);
        tick(3);
        check(status_char, exp_char(3'(m), 1'(u)));
        check(status_code, exp_code(3'(m), 1'(u)));
        send(3'h1, 1'(u));
      end
    end
    sensor_unstable <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      prefix_sel <= p[0];
      send(3'h2, 1'b0);
      send(3'h4, 1'b0);
    end
    aid_mode <= 3'h5;
    send(3'h7, 1'b0);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
    tick(3);
    check(aligning, 1'b1);
    send(3'h1, 1'b1);
    wait_aligned();
    finish_test();
  end
endmodule
`default_nettype wire
